// ===== design/abts_defines.svh
/*
 Constants of the command/response transport block: instruction codes,
 status words, header layout, response block sizing and reset values.
 Assumes nothing; holds definitions only.
*/
`ifndef ABTS_DEFINES_SVH
`define ABTS_DEFINES_SVH

// Instruction codes that the block recognises.
`define ABTS_INS_FETCH 8'h12
`define ABTS_INS_TERM_RSP 8'h14
`define ABTS_INS_ENVELOPE 8'hc2

// Status words and first status bytes.
`define ABTS_SW_OK 16'h9000
`define ABTS_SW_TK_BUSY 16'h9300
`define ABTS_SW1_PENDING 8'h91
`define ABTS_SW1_NORMAL 8'h61
`define ABTS_SW1_WARN_A 8'h62
`define ABTS_SW1_WARN_B 8'h63
`define ABTS_SW1_APP_NIBBLE 4'h9

// Command header layout: byte index of each field.
`define ABTS_IDX_CLA 9'h000
`define ABTS_IDX_INS 9'h001
`define ABTS_IDX_P1 9'h002
`define ABTS_IDX_P2 9'h003
`define ABTS_IDX_P3 9'h004
`define ABTS_IDX_BODY 9'h005

// Response sizing and reset values.
`define ABTS_IFS_DEFAULT 32
`define ABTS_FIFO_DEPTH 16
`define ABTS_BYTE_RST 8'h00
`define ABTS_SW_RST 16'h0000

`endif

// ===== design/abts_pkg.sv
/*
 Types shared by the transport block: state codes, exchange cases and the
 packed carriers for a command header and for one outgoing INF byte.
 Assumes nothing of its surroundings.
*/
package abts_pkg;

   // One-hot states of the exchange sequencer.
   typedef enum logic [4:0] {
      ST_RX = 5'h01,
      ST_EXEC = 5'h02,
      ST_DATA = 5'h04,
      ST_SW1 = 5'h08,
      ST_SW2 = 5'h10
   } abts_state_type;

   // The four exchange cases, by presence of command and response data.
   typedef enum logic [1:0] {
      CASE_1 = 2'h0,
      CASE_2 = 2'h1,
      CASE_3 = 2'h2,
      CASE_4 = 2'h3
   } abts_case_type;

   // Decoded command header handed to the application.
   typedef struct packed {
      logic [7:0] cla;
      logic [7:0] ins;
      logic [7:0] p1;
      logic [7:0] p2;
      abts_case_type ncase;
      logic [7:0] lc;
      logic [7:0] le;
   } abts_hdr_type;

   // One byte of an outgoing INF, with block end and chaining marks.
   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic chain;
   } abts_blk_byte_type;

endpackage

// ===== design/abts_fifo.sv
/*
 Synchronous FIFO of flip-flops with valid/ready on both sides.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "abts_defines.svh"

module abts_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `ABTS_FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Filling side.
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // Draining side.
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
   logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
   logic [AW:0] count_ff, nxt_count;
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////////
   // Full and empty come straight from the occupancy count.
   assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
   assign out_valid_o = (count_ff != '0);
   assign out_data_o = mem_ff[rd_ptr_ff];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Pointers wrap explicitly so a depth that is not a power of two works.
   always_comb begin
      nxt_wr_ptr = wr_ptr_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_count = count_ff;
      if (push) begin
         nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + AW'(1);
      end
      if (pop) begin
         nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + AW'(1);
      end
      if (push && !pop) begin
         nxt_count = count_ff + (AW+1)'(1);
      end else if (pop && !push) begin
         nxt_count = count_ff - (AW+1)'(1);
      end
   end

   // Storage is not reset; only the pointers and the count say what is valid.
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   // Pointer and count registers.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff <= nxt_count;
      end
   end

endmodule

`default_nettype wire

// ===== design/abts_core.sv
/*
 Card-side command/response transport over chained information blocks.
 Assumes the block layer below delivers INF bytes of valid I-blocks on the
 same clock, and an application that answers each header pulse once.
*/
`timescale 1ns/1ns
`default_nettype none
`include "abts_defines.svh"

module abts_core #(
   parameter int IFS = `ABTS_IFS_DEFAULT,
   parameter int FIFO_DEPTH = `ABTS_FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Incoming INF bytes from the block layer.
   input wire logic blk_valid_i,
   input wire logic [7:0] blk_data_i,
   input wire logic blk_last_i,
   input wire logic blk_chain_i,
   output logic blk_ready_o,
   // Outgoing INF bytes to the block layer.
   output logic rsp_valid_o,
   output abts_pkg::abts_blk_byte_type rsp_byte_o,
   input wire logic rsp_ready_i,
   // Command towards the application.
   output logic cmd_data_valid_o,
   output logic [7:0] cmd_data_o,
   input wire logic cmd_data_ready_i,
   output logic cmd_hdr_valid_o,
   output abts_pkg::abts_hdr_type cmd_hdr_o,
   // Response from the application.
   input wire logic app_sw_valid_i,
   input wire logic [15:0] app_sw_i,
   input wire logic app_sw_data_i,
   input wire logic app_data_valid_i,
   input wire logic [7:0] app_data_i,
   input wire logic app_data_last_i,
   output logic app_data_ready_o,
   // Toolkit state.
   input wire logic tk_pend_i,
   input wire logic [7:0] tk_pend_len_i,
   input wire logic tk_busy_i
);

   // Statuses that may carry response data; 9000 falls in the 9X group.
   function automatic logic sw_allows_data(input logic [15:0] sw);
      logic [7:0] sw1;
      sw1 = sw[15:8];
      sw_allows_data = (sw1 == `ABTS_SW1_NORMAL) || (sw1 == `ABTS_SW1_WARN_A) ||
                       (sw1 == `ABTS_SW1_WARN_B) || (sw1[7:4] == `ABTS_SW1_APP_NIBBLE);
   endfunction

   abts_pkg::abts_state_type state_ff, nxt_state;
   abts_pkg::abts_hdr_type hdr_ff, nxt_hdr;
   abts_pkg::abts_blk_byte_type out_ff, nxt_out;
   logic [8:0] idx_ff, nxt_idx;
   logic [8:0] fwd_cnt_ff, nxt_fwd_cnt;
   logic [7:0] p3_ff, nxt_p3;
   logic drop_ff, nxt_drop;
   logic cmd_valid_ff, nxt_cmd_valid;
   logic [7:0] cmd_data_ff, nxt_cmd_data;
   logic hdr_valid_ff, nxt_hdr_valid;
   logic [15:0] sw_ff, nxt_sw;
   logic allow_ff, nxt_allow;
   logic out_valid_ff, nxt_out_valid;
   logic [7:0] blk_cnt_ff, nxt_blk_cnt;
   logic sent_ff, nxt_sent;
   logic in_take;
   logic fwd_byte;
   logic msg_end;
   logic load_en;
   logic fifo_push;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic fifo_pop;
   logic [15:0] final_sw;

   ////////////////////////////////////////////////////////////////////////
   // Handshakes. No new command is taken until the second status byte has been loaded into the output register.
   assign blk_ready_o = (state_ff == abts_pkg::ST_RX) &&
                        (!cmd_valid_ff || cmd_data_ready_i);
   assign in_take = blk_valid_i && blk_ready_o;
   assign msg_end = in_take && blk_last_i && !blk_chain_i;
   assign fwd_byte = (idx_ff >= `ABTS_IDX_BODY) &&
                     (idx_ff < (`ABTS_IDX_BODY + {1'b0, p3_ff})) && !drop_ff;
   assign app_data_ready_o = (state_ff == abts_pkg::ST_DATA) &&
                             (!allow_ff || fifo_in_ready);
   // Bytes of a status that may not carry data are accepted and discarded.
   assign fifo_push = (state_ff == abts_pkg::ST_DATA) && app_data_valid_i &&
                      allow_ff && fifo_in_ready;
   assign load_en = !out_valid_ff || rsp_ready_i;
   assign fifo_pop = load_en && fifo_out_valid;
   assign cmd_data_valid_o = cmd_valid_ff;
   assign cmd_data_o = cmd_data_ff;
   assign cmd_hdr_valid_o = hdr_valid_ff;
   assign cmd_hdr_o = hdr_ff;
   assign rsp_valid_o = out_valid_ff;
   assign rsp_byte_o = out_ff;

   // Success is replaced by the pending-command status unless this very
   // command is the retrieval, whose answer must stay a plain success.
   always_comb begin
      final_sw = app_sw_i;
      if ((app_sw_i == `ABTS_SW_OK) && tk_pend_i && (hdr_ff.ins != `ABTS_INS_FETCH)) begin
         final_sw = {`ABTS_SW1_PENDING, tk_pend_len_i};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Response bytes wait here while the block layer stalls.
   abts_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_rsp_fifo (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .in_valid_i(fifo_push),
      .in_data_i(app_data_i),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(fifo_out_valid),
      .out_data_o(fifo_out_data),
      .out_ready_i(load_en)
   );

   ////////////////////////////////////////////////////////////////////////
   // Command reception and exchange sequencing. The header is decoded on
   // the fly; body bytes stream to the application as they arrive, so the
   // header pulse marks the end of the whole concatenated command.
   always_comb begin
      nxt_state = state_ff;
      nxt_idx = idx_ff;
      nxt_hdr = hdr_ff;
      nxt_p3 = p3_ff;
      nxt_drop = drop_ff;
      nxt_fwd_cnt = fwd_cnt_ff;
      nxt_cmd_valid = cmd_valid_ff && !cmd_data_ready_i;
      nxt_cmd_data = cmd_data_ff;
      nxt_hdr_valid = 1'b0;
      nxt_sw = sw_ff;
      nxt_allow = allow_ff;
      case (state_ff)
         abts_pkg::ST_RX: begin
            if (in_take) begin
               nxt_idx = idx_ff + 9'h001;
               case (idx_ff)
                  `ABTS_IDX_CLA: begin
                     nxt_hdr.cla = blk_data_i;
                     nxt_fwd_cnt = 9'h000;
                  end
                  `ABTS_IDX_INS: begin
                     nxt_hdr.ins = blk_data_i;
                     nxt_drop = (blk_data_i == `ABTS_INS_ENVELOPE) && tk_busy_i;
                  end
                  `ABTS_IDX_P1: nxt_hdr.p1 = blk_data_i;
                  `ABTS_IDX_P2: nxt_hdr.p2 = blk_data_i;
                  `ABTS_IDX_P3: nxt_p3 = blk_data_i;
                  default: begin
                     if (fwd_byte) begin
                        nxt_cmd_valid = 1'b1;
                        nxt_cmd_data = blk_data_i;
                        nxt_fwd_cnt = fwd_cnt_ff + 9'h001;
                     end
                  end
               endcase
               if (msg_end) begin
                  nxt_idx = 9'h000;
                  nxt_hdr.lc = 8'h00;
                  nxt_hdr.le = 8'h00;
                  // Class the exchange by the length of the body.
                  if (idx_ff == `ABTS_IDX_P2) begin
                     nxt_hdr.ncase = abts_pkg::CASE_1;
                  end else if (idx_ff == `ABTS_IDX_P3) begin
                     nxt_hdr.ncase = abts_pkg::CASE_2;
                     nxt_hdr.le = blk_data_i;
                  end else if (idx_ff == (`ABTS_IDX_P3 + {1'b0, p3_ff})) begin
                     nxt_hdr.ncase = abts_pkg::CASE_3;
                     nxt_hdr.lc = p3_ff;
                  end else begin
                     nxt_hdr.ncase = abts_pkg::CASE_4;
                     nxt_hdr.lc = p3_ff;
                     nxt_hdr.le = blk_data_i;
                  end
                  if (drop_ff) begin
                     nxt_sw = `ABTS_SW_TK_BUSY;
                     nxt_allow = 1'b0;
                     nxt_state = abts_pkg::ST_SW1;
                  end else begin
                     nxt_hdr_valid = 1'b1;
                     nxt_state = abts_pkg::ST_EXEC;
                  end
               end
            end
         end
         abts_pkg::ST_EXEC: begin
            if (app_sw_valid_i) begin
               nxt_sw = final_sw;
               nxt_allow = sw_allows_data(final_sw);
               nxt_state = app_sw_data_i ? abts_pkg::ST_DATA : abts_pkg::ST_SW1;
            end
         end
         abts_pkg::ST_DATA: begin
            if (app_data_valid_i && app_data_ready_o && app_data_last_i) begin
               nxt_state = abts_pkg::ST_SW1;
            end
         end
         abts_pkg::ST_SW1: begin
            if (load_en && !fifo_out_valid) begin
               nxt_state = abts_pkg::ST_SW2;
            end
         end
         abts_pkg::ST_SW2: begin
            if (load_en) begin
               nxt_state = abts_pkg::ST_RX;
            end
         end
         default: nxt_state = abts_pkg::ST_RX;
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= abts_pkg::ST_RX;
         idx_ff <= 9'h000;
         hdr_ff <= '0;
         p3_ff <= `ABTS_BYTE_RST;
         drop_ff <= 1'b0;
         fwd_cnt_ff <= 9'h000;
         cmd_valid_ff <= 1'b0;
         cmd_data_ff <= `ABTS_BYTE_RST;
         hdr_valid_ff <= 1'b0;
         sw_ff <= `ABTS_SW_RST;
         allow_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         idx_ff <= nxt_idx;
         hdr_ff <= nxt_hdr;
         p3_ff <= nxt_p3;
         drop_ff <= nxt_drop;
         fwd_cnt_ff <= nxt_fwd_cnt;
         cmd_valid_ff <= nxt_cmd_valid;
         cmd_data_ff <= nxt_cmd_data;
         hdr_valid_ff <= nxt_hdr_valid;
         sw_ff <= nxt_sw;
         allow_ff <= nxt_allow;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output stage: data first, then the two status bytes. A block closes
   // at IFS bytes with chaining set, or at the second status byte, which
   // always ends the message; so the stage never needs to look ahead.
   always_comb begin
      nxt_out_valid = out_valid_ff;
      nxt_out = out_ff;
      nxt_blk_cnt = blk_cnt_ff;
      nxt_sent = sent_ff;
      if (load_en) begin
         nxt_out_valid = 1'b0;
         if (fifo_out_valid || (state_ff == abts_pkg::ST_SW1) ||
             (state_ff == abts_pkg::ST_SW2)) begin
            nxt_out_valid = 1'b1;
            nxt_out.last = (blk_cnt_ff == 8'(IFS-1));
            nxt_out.chain = nxt_out.last;
            if (fifo_out_valid) begin
               nxt_out.data = fifo_out_data;
               nxt_sent = 1'b1;
            end else if (state_ff == abts_pkg::ST_SW1) begin
               nxt_out.data = sw_ff[15:8];
            end else begin
               nxt_out.data = sw_ff[7:0];
               nxt_out.last = 1'b1;
               nxt_out.chain = 1'b0;
               nxt_sent = 1'b0;
            end
            nxt_blk_cnt = nxt_out.last ? 8'h00 : blk_cnt_ff + 8'h01;
         end
      end
   end

   // Output registers.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_valid_ff <= 1'b0;
         out_ff <= '0;
         blk_cnt_ff <= 8'h00;
         sent_ff <= 1'b0;
      end else begin
         out_valid_ff <= nxt_out_valid;
         out_ff <= nxt_out;
         blk_cnt_ff <= nxt_blk_cnt;
         sent_ff <= nxt_sent;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks on the sequencer and the output stage.
   a_no_data_sw:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (load_en && !fifo_out_valid && state_ff == abts_pkg::ST_SW1 &&
       !sw_allows_data(sw_ff)) |-> !sent_ff)
      else $error("response data sent with a status that forbids it");

   a_data_gate:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      fifo_push |-> sw_allows_data(sw_ff))
      else $error("response byte queued under a data-free status");

   a_pend_subst:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_ff == abts_pkg::ST_EXEC && app_sw_valid_i && app_sw_i == `ABTS_SW_OK &&
       tk_pend_i && hdr_ff.ins != `ABTS_INS_FETCH)
      |=> sw_ff == {`ABTS_SW1_PENDING, $past(tk_pend_len_i)})
      else $error("pending command not signalled in place of success");

   a_fetch_ok:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_ff == abts_pkg::ST_EXEC && app_sw_valid_i && app_sw_i == `ABTS_SW_OK &&
       hdr_ff.ins == `ABTS_INS_FETCH) |=> sw_ff == `ABTS_SW_OK)
      else $error("retrieval answer lost its success status");

   a_busy_reply:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (msg_end && drop_ff) |=> (sw_ff == `ABTS_SW_TK_BUSY) &&
      (state_ff == abts_pkg::ST_SW1) && !cmd_hdr_valid_o)
      else $error("busy toolkit did not answer the data-wrap command");

   a_one_cmd:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_ff != abts_pkg::ST_RX) |-> !blk_ready_o)
      else $error("command accepted while a response is open");

   a_hdr_after_end:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (msg_end && !drop_ff) |=> cmd_hdr_valid_o ##1 !cmd_hdr_valid_o)
      else $error("header pulse not given once after the final block");

   a_case_body:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (cmd_hdr_valid_o && (cmd_hdr_o.ncase == abts_pkg::CASE_3 ||
       cmd_hdr_o.ncase == abts_pkg::CASE_4)) |-> fwd_cnt_ff == {1'b0, cmd_hdr_o.lc})
      else $error("forwarded body length differs from the command length");

   a_block_size:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (rsp_valid_o && rsp_byte_o.chain && $past(load_en)) |->
      rsp_byte_o.last && $past(blk_cnt_ff) == 8'(IFS-1))
      else $error("chained block closed at the wrong size");

   a_status_tail:
   assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (rsp_valid_o && rsp_byte_o.last && !rsp_byte_o.chain) |-> rsp_byte_o.data == sw_ff[7:0])
      else $error("message did not end with the second status byte");

endmodule

`default_nettype wire

// ===== verif/abts_term_model.sv
/*
 Terminal-side transport model: sends command INF bytes in chained blocks
 and gathers the response INF bytes unchanged.
 Assumes the core's clock and reset, and a bench that calls send.
*/
`timescale 1ns/1ns
`default_nettype none

module abts_term_model (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Command INF bytes towards the card side.
   output logic blk_valid_o,
   output logic [7:0] blk_data_o,
   output logic blk_last_o,
   output logic blk_chain_o,
   input wire logic blk_ready_i,
   // Response INF bytes from the card side.
   input wire logic rsp_valid_i,
   input wire abts_pkg::abts_blk_byte_type rsp_byte_i,
   output logic rsp_ready_o
);
   abts_pkg::abts_blk_byte_type rx_q[$];

   ////////////////////////////////////////////////////////////////////////
   // Idle values; the data line shows a moving pattern when released.
   initial begin
      blk_valid_o = 1'b0;
      blk_data_o = 8'h5a;
      blk_last_o = 1'b0;
      blk_chain_o = 1'b0;
      rsp_ready_o = 1'b0;
   end

   // Sends one message unmodified, closing a block every blk_len bytes.
   task automatic send(input logic [7:0] msg[$], input int blk_len);
      int i;
      for (i = 0; i < msg.size(); i++) begin
         blk_valid_o <= 1'b1;
         blk_data_o <= msg[i];
         blk_last_o <= ((i + 1) % blk_len == 0) || (i == msg.size() - 1);
         blk_chain_o <= (i != msg.size() - 1);
         do @(posedge clk_sys_i); while (blk_ready_i !== 1'b1);
      end
      blk_valid_o <= 1'b0;
      blk_data_o <= ~blk_data_o;
   endtask

   // Keeps received bytes in order; ready stalls at random so the FIFO backs up.
   always @(posedge clk_sys_i) begin
      if (rsp_valid_i === 1'b1 && rsp_ready_o) rx_q.push_back(rsp_byte_i);
      rsp_ready_o <= ($urandom_range(3) != 0);
   end

endmodule

`default_nettype wire

// ===== verif/tb_top.sv
/*
 Self-checking bench of the transport core: random and corner exchanges.
 Assumes the terminal model and the core share one 125 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "abts_defines.svh"

module tb_top;
   localparam int IFS = 8;
   logic clk_sys_i, resetn_i, blk_valid, blk_last, blk_chain, blk_ready, rsp_valid, rsp_ready;
   logic [7:0] blk_data, cmd_data, app_data, tk_pend_len;
   logic cmd_data_valid, cmd_data_ready, cmd_hdr_valid, app_sw_valid, app_sw_data;
   logic app_data_valid, app_data_last, app_data_ready, tk_pend, tk_busy;
   logic [15:0] app_sw;
   abts_pkg::abts_blk_byte_type rsp_byte;
   abts_pkg::abts_hdr_type cmd_hdr;
   logic [7:0] cmd_q[$];
   logic [15:0] sws[8] = '{16'h6101, 16'h62f1, 16'h6300, 16'h9f10, 16'h9000, 16'h6a82,
                           16'h6d00, 16'h6e00};
   int errors = 0, check_count = 0, hdr_cnt = 0, cyc = 0, k;

   ////////////////////////////////////////////////////////////////////////
   // Devices: the core and the terminal on its link side.
   abts_core #(.IFS(IFS), .FIFO_DEPTH(16)) DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .blk_valid_i(blk_valid), .blk_data_i(blk_data), .blk_last_i(blk_last),
      .blk_chain_i(blk_chain), .blk_ready_o(blk_ready), .rsp_valid_o(rsp_valid),
      .rsp_byte_o(rsp_byte), .rsp_ready_i(rsp_ready), .cmd_data_valid_o(cmd_data_valid),
      .cmd_data_o(cmd_data), .cmd_data_ready_i(cmd_data_ready), .cmd_hdr_valid_o(cmd_hdr_valid),
      .cmd_hdr_o(cmd_hdr), .app_sw_valid_i(app_sw_valid), .app_sw_i(app_sw),
      .app_sw_data_i(app_sw_data), .app_data_valid_i(app_data_valid), .app_data_i(app_data),
      .app_data_last_i(app_data_last), .app_data_ready_o(app_data_ready),
      .tk_pend_i(tk_pend), .tk_pend_len_i(tk_pend_len), .tk_busy_i(tk_busy));
   abts_term_model term (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .blk_valid_o(blk_valid),
      .blk_data_o(blk_data), .blk_last_o(blk_last), .blk_chain_o(blk_chain),
      .blk_ready_i(blk_ready), .rsp_valid_i(rsp_valid), .rsp_byte_i(rsp_byte),
      .rsp_ready_o(rsp_ready));

   // Clock of 8 ns.
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   // Application side: body bytes gathered, header pulses counted, hang guard.
   always @(posedge clk_sys_i) begin
      if (cmd_data_valid === 1'b1 && cmd_data_ready) cmd_q.push_back(cmd_data);
      if (cmd_hdr_valid === 1'b1) hdr_cnt <= hdr_cnt + 1;
      cmd_data_ready <= ($urandom_range(3) != 0);
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Status the card side should send, after pending and busy substitution.
   function automatic logic [15:0] exp_sw(input logic [7:0] ins, input logic [15:0] sw,
         input logic busy);
      if (busy) return `ABTS_SW_TK_BUSY;
      if (sw == `ABTS_SW_OK && tk_pend && ins != `ABTS_INS_FETCH)
         return {`ABTS_SW1_PENDING, tk_pend_len};
      return sw;
   endfunction

   // One command/response pair; le below zero leaves the Le byte out.
   task automatic exchange(input logic [7:0] ins, input int lc, input int le, input int blk,
         input logic [15:0] sw, input int nd, input logic busy);
      logic [7:0] msg[$], body[$], exp_q[$];
      logic [15:0] swx;
      logic lst;
      int i, h0, t, n;
      msg = {8'h80, ins, 8'($urandom), 8'($urandom)};
      if (lc > 0) msg.push_back(8'(lc));
      for (i = 0; i < lc; i++) begin
         body.push_back(8'($urandom));
         msg.push_back(body[i]);
      end
      if (le >= 0) msg.push_back(8'(le));
      term.rx_q.delete();
      cmd_q.delete();
      h0 = hdr_cnt;
      term.send(msg, blk);
      swx = exp_sw(ins, sw, busy);
      if (!busy) begin
         t = 0;
         while ((hdr_cnt == h0 || cmd_q.size() < lc) && t < 50) begin
            @(posedge clk_sys_i);
            t++;
         end
         check("header pulses", 16'h1, 16'(hdr_cnt - h0));
         check("header ins", {8'h00, ins}, {8'h00, cmd_hdr.ins});
         check("case", 16'(lc == 0 ? (le < 0 ? 0 : 1) : (le < 0 ? 2 : 3)), 16'(cmd_hdr.ncase));
         check("body count", 16'(lc), 16'(cmd_q.size()));
         for (i = 0; i < lc; i++) check("body byte", {8'h00, body[i]}, {8'h00, cmd_q[i]});
         app_sw_valid <= 1'b1;
         app_sw <= sw;
         app_sw_data <= (nd > 0);
         @(posedge clk_sys_i);
         app_sw_valid <= 1'b0;
         for (i = 0; i < nd; i++) begin
            msg[0] = 8'($urandom);
            if (swx[15:8] inside {8'h61, 8'h62, 8'h63} || swx[15:12] == 4'h9)
               exp_q.push_back(msg[0]);
            app_data_valid <= 1'b1;
            app_data <= msg[0];
            app_data_last <= (i == nd - 1);
            do @(posedge clk_sys_i); while (app_data_ready !== 1'b1);
         end
         app_data_valid <= 1'b0;
         app_data <= ~app_data;
      end
      exp_q.push_back(swx[15:8]);
      exp_q.push_back(swx[7:0]);
      t = 0;
      while (!(term.rx_q.size() > 0 && term.rx_q[$].last && !term.rx_q[$].chain) && t < 800) begin
         @(posedge clk_sys_i);
         t++;
      end
      if (busy) check("busy header pulses", 16'h0, 16'(hdr_cnt - h0));
      n = exp_q.size();
      check("response length", 16'(n), 16'(term.rx_q.size()));
      for (i = 0; i < n && i < term.rx_q.size(); i++) begin
         lst = ((i + 1) % IFS == 0) || (i == n - 1);
         check("response byte", {8'h00, exp_q[i]}, {8'h00, term.rx_q[i].data});
         check("block marks", {14'h0, lst, lst && i != n - 1},
               {14'h0, term.rx_q[i].last, term.rx_q[i].chain});
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, corner cases, random traffic, toolkit flows.
   initial begin
      resetn_i = 1'b0;
      {app_sw_valid, app_sw_data, app_data_valid, app_data_last, tk_pend, tk_busy} = '0;
      {app_sw, app_data, tk_pend_len} = '0;
      void'($urandom(32'h46e5));
      repeat (4) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      @(posedge clk_sys_i);
      exchange(8'hb0, 0, -1, 8, 16'h6a82, 0, 0);
      foreach (sws[k]) exchange(8'hb0, 0, 5, 8, sws[k], 1 + $urandom_range(9), 0);
      for (k = 0; k < 8; k++)
         exchange(8'(8'h20 + k), $urandom_range(20), (k % 2) ? -1 : 0, 1 + $urandom_range(5),
                  sws[$urandom_range(7)], $urandom_range(40), 0);
      tk_pend <= 1'b1;
      tk_pend_len <= 8'h1b;
      exchange(8'ha4, 3, 0, 4, `ABTS_SW_OK, 2, 0);
      exchange(`ABTS_INS_FETCH, 0, 8'h1b, 8, `ABTS_SW_OK, 27, 0);
      exchange(`ABTS_INS_TERM_RSP, 5, -1, 8, `ABTS_SW_OK, 0, 0);
      tk_pend <= 1'b0;
      tk_busy <= 1'b1;
      exchange(`ABTS_INS_ENVELOPE, 6, 0, 3, `ABTS_SW_OK, 0, 1);
      tk_busy <= 1'b0;
      exchange(`ABTS_INS_ENVELOPE, 6, 0, 3, `ABTS_SW_OK, 4, 0);
      exchange(`ABTS_INS_ENVELOPE, 6, 0, 3, 16'h62a0, 4, 0);
      close_out();
   end

endmodule

`default_nettype wire
